// File: rwd_handler.sv
// register write parser and name, status and capability responder
`timescale 1ns/1ns
`default_nettype none
module rwd_handler
    import rwd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    // incoming frames from the link
    input wire logic frame_valid_i,
    input wire logic frame_cmd_i,
    input wire logic [7:0] frame_data_i,
    // one-cycle pulse at the end of a write command
    input wire logic cmd_done_i,
    output logic frame_ready_o,
    // capability straps
    input wire logic single_wr_en_i,
    input wire logic burst_wr_en_i,
    input wire logic read_en_i,
    input wire logic name_en_i,
    input wire logic status_en_i,
    input wire logic nationality_en_i,
    input wire logic [6:0] max_read_addr_i,
    input wire logic [7:0] nationality_code_i,
    input wire logic [7:0] status_byte_i,
    // register write port, via the two-entry buffer
    output logic wr_valid_o,
    output logic [6:0] wr_addr_o,
    output logic [7:0] wr_data_o,
    output logic wr_burst_o,
    input wire logic wr_ready_i,
    // response frames
    output logic resp_valid_o,
    output logic [7:0] resp_data_o,
    output logic resp_last_o,
    input wire logic resp_ready_i,
    // status
    output logic burst_overflow_o
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        rwd_state_e state;
        // parser: pair address, burst target
        // and burst bytes taken so far
        logic [6:0] single_addr;
        logic [6:0] burst_addr;
        logic [15:0] burst_cnt;
        logic burst_overflow;
        // write buffer: entry 0 is the head
        // shown on the write port
        logic [1:0] buf_cnt;
        logic [6:0] buf0_addr;
        logic [7:0] buf0_data;
        logic buf0_burst;
        logic [6:0] buf1_addr;
        logic [7:0] buf1_data;
        logic buf1_burst;
        logic wr_valid;
        logic frame_ready;
        // response stream: kind, position, length
        // and the registered output byte
        rwd_resp_e resp_kind;
        logic [3:0] resp_idx;
        logic [3:0] resp_len;
        logic resp_valid;
        logic [7:0] resp_data;
        logic resp_last;
    } rwd_state_s;

    rwd_state_s state_reg;
    rwd_state_s state_next;

    // one slot per record field; six slots
    // cover every flag set at once
    logic [7:0] cap_rec [0:5];
    logic [3:0] cap_len;
    // frame accepted now, and the write it
    // hands to the buffer, if any
    logic fire;
    logic push;
    logic [6:0] push_addr;
    logic [7:0] push_data;
    logic push_burst;
    logic [7:0] resp_byte;

    // ************************************************************
    // capability record assembly
    // ************************************************************
    // fields are packed in fixed order, skipping those not flagged,
    // so the record length follows directly from the straps
    always_comb begin
        // clean record each cycle so unflagged
        // slots never carry stale bytes
        cap_len = 4'h1;
        for (int k = 0; k < 6; k++) begin
            cap_rec[k] = 8'h00;
        end
        cap_rec[0][7] = 1'b0; // reserved
        cap_rec[0][HDR_NATIONALITY_BIT] = nationality_en_i;
        cap_rec[0][HDR_STATUS_BIT] = status_en_i;
        cap_rec[0][HDR_NAME_BIT] = name_en_i;
        cap_rec[0][3] = 1'b0; // reserved
        cap_rec[0][HDR_READ_BIT] = read_en_i;
        cap_rec[0][HDR_BURST_BIT] = burst_wr_en_i;
        cap_rec[0][HDR_SINGLE_BIT] = single_wr_en_i;
        // header always present, at most six bytes in all
        if (read_en_i) begin
            cap_rec[cap_len[2:0]] = {1'b0, max_read_addr_i};
            cap_len = cap_len + 4'h1;
        end
        if (single_wr_en_i || burst_wr_en_i) begin
            cap_rec[cap_len[2:0]] = {1'b0, MAX_WRITE_ADDR};
            cap_len = cap_len + 4'h1;
        end
        if (burst_wr_en_i) begin
            cap_rec[cap_len[2:0]] = BURST_ADVERT[7:0]; // low first
            cap_len = cap_len + 4'h1;
            cap_rec[cap_len[2:0]] = BURST_ADVERT[15:8];
            cap_len = cap_len + 4'h1;
        end
        if (nationality_en_i) begin
            cap_rec[cap_len[2:0]] = nationality_code_i; // last field
            cap_len = cap_len + 4'h1;
        end
    end

    // ************************************************************
    // response byte selection
    // ************************************************************
    // straps and status are read live while the response runs;
    // they are expected to hold still during a report
    always_comb begin
        resp_byte = 8'h00;
        case (state_reg.resp_kind)
            RK_NAME: begin
                // first character in the top byte
                resp_byte = NAME_TEXT[8*(14 - 32'(state_reg.resp_idx)) +: 8];
            end
            RK_STATUS: begin
                // single byte, see the status length
                resp_byte = status_byte_i;
            end
            RK_CAP: begin
                // slots past the record read as zero
                if (state_reg.resp_idx < 4'h6) begin
                    resp_byte = cap_rec[state_reg.resp_idx[2:0]];
                end
            end
            default: begin
                resp_byte = 8'h00;
            end
        endcase
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        // hold by default; each branch below
        // changes only the fields it owns
        state_next = state_reg;
        fire = frame_valid_i && state_reg.frame_ready;
        push = 1'b0;
        push_addr = 7'h00;
        push_data = 8'h00;
        push_burst = 1'b0;

        // a finished write command closes any pair or burst
        // a pair cut after its address writes nothing
        if (cmd_done_i && state_reg.state != ST_RESP) begin
            state_next.state = ST_IDLE;
        end

        // a command frame beats any parser state:
        // the host may abandon a write at any point
        if (fire && frame_cmd_i) begin
            // a new command always ends burst mode
            state_next.state = ST_IDLE;
            state_next.burst_overflow = 1'b0;
            case (frame_data_i)
                REGISTER_WRITE_COMMAND: begin
                    // no write capability: stay idle, data frames fall away
                    if (single_wr_en_i || burst_wr_en_i) begin
                        state_next.state = ST_WR_ADDR;
                    end
                end
                // name and status need their strap
                NAME_REPORT_COMMAND: begin
                    if (name_en_i) begin
                        state_next.state = ST_RESP;
                        state_next.resp_kind = RK_NAME;
                        state_next.resp_len = NAME_LEN;
                        state_next.resp_idx = 4'h0;
                    end
                end
                STATUS_REPORT_COMMAND: begin
                    if (status_en_i) begin
                        state_next.state = ST_RESP;
                        state_next.resp_kind = RK_STATUS;
                        state_next.resp_len = STATUS_LEN;
                        state_next.resp_idx = 4'h0;
                    end
                end
                EXTENDED_CAPABILITY_COMMAND: begin
                    state_next.state = ST_RESP;
                    state_next.resp_kind = RK_CAP;
                    state_next.resp_len = cap_len;
                    state_next.resp_idx = 4'h0;
                end
                default: begin
                    state_next.state = ST_IDLE;
                end
            endcase
        end else if (fire) begin
            case (state_reg.state)
                ST_WR_ADDR: begin
                    // top bit of the address byte picks the form
                    if (frame_data_i[7]) begin
                        // burst address: everything after it is data
                        state_next.burst_addr = frame_data_i[6:0];
                        state_next.burst_cnt = 16'h0000;
                        state_next.state = burst_wr_en_i ? ST_WR_BURST : ST_IDLE;
                    end else begin
                        // unsupported form drops the rest of the command
                        state_next.single_addr = frame_data_i[6:0];
                        state_next.state = single_wr_en_i ? ST_WR_DATA : ST_IDLE;
                    end
                end
                ST_WR_DATA: begin
                    push = 1'b1;
                    push_addr = state_reg.single_addr;
                    push_data = frame_data_i;
                    state_next.state = ST_WR_ADDR; // next pair may follow
                end
                ST_WR_BURST: begin
                    // only the burst target is ever written here
                    // once full the count stops; later bytes
                    // only raise the sticky flag
                    if (state_reg.burst_cnt < BURST_BUF_BYTES) begin
                        push = 1'b1; // arrival order kept
                        push_addr = state_reg.burst_addr;
                        push_data = frame_data_i;
                        push_burst = 1'b1;
                        state_next.burst_cnt = state_reg.burst_cnt + 16'h0001;
                    end else begin
                        state_next.burst_overflow = 1'b1;
                    end
                end
                default: begin
                    // idle data frames are discarded
                    state_next.state = state_reg.state;
                end
            endcase
        end

        // two-entry buffer: pop shifts, then push fills the free slot
        // the push slot follows the count after the pop,
        // so a one-entry buffer drained in the same cycle
        // keeps its order
        if (state_reg.buf_cnt != 2'h0 && wr_ready_i) begin
            state_next.buf0_addr = state_reg.buf1_addr;
            state_next.buf0_data = state_reg.buf1_data;
            state_next.buf0_burst = state_reg.buf1_burst;
            state_next.buf_cnt = state_reg.buf_cnt - 2'h1;
        end
        if (push) begin
            if (state_next.buf_cnt == 2'h0) begin
                state_next.buf0_addr = push_addr;
                state_next.buf0_data = push_data;
                state_next.buf0_burst = push_burst;
            end else begin
                state_next.buf1_addr = push_addr;
                state_next.buf1_data = push_data;
                state_next.buf1_burst = push_burst;
            end
            state_next.buf_cnt = state_next.buf_cnt + 2'h1;
        end
        // valid comes from the next count, so it
        // never lags the buffer content
        state_next.wr_valid = (state_next.buf_cnt != 2'h0);

        // response sequencer: next byte loads once the last is taken
        // the index counts loaded bytes; at the length
        // the stream closes and frames open again
        if (state_reg.state == ST_RESP) begin
            if (!state_reg.resp_valid || resp_ready_i) begin
                if (state_reg.resp_idx < state_reg.resp_len) begin
                    state_next.resp_valid = 1'b1;
                    state_next.resp_data = resp_byte;
                    state_next.resp_last = (state_reg.resp_idx == state_reg.resp_len - 4'h1);
                    state_next.resp_idx = state_reg.resp_idx + 4'h1;
                end else begin
                    state_next.resp_valid = 1'b0;
                    state_next.resp_last = 1'b0;
                    state_next.state = ST_IDLE;
                end
            end
        end

        // frames are refused while responding or while the buffer is full,
        // so a stalled register sink never loses a written byte
        // judged on the state of the next cycle,
        // since ready itself is registered
        state_next.frame_ready = (state_next.state != ST_RESP) &&
            (state_next.buf_cnt < BUF_DEPTH);
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // enum fields set by name so the start
            // state does not hang on an encoding
            state_reg <= '0;
            state_reg.state <= ST_IDLE;
            state_reg.resp_kind <= RK_NAME;
        end else begin
            state_reg <= state_next;
        end
    end

    // ************************************************************
    // outputs, all straight from the state register
    // ************************************************************
    // no gate between flop and pin: only
    // clock-to-output reaches the far side
    assign frame_ready_o = state_reg.frame_ready;
    assign wr_valid_o = state_reg.wr_valid;
    assign wr_addr_o = state_reg.buf0_addr;
    assign wr_data_o = state_reg.buf0_data;
    assign wr_burst_o = state_reg.buf0_burst;
    assign resp_valid_o = state_reg.resp_valid;
    assign resp_data_o = state_reg.resp_data;
    assign resp_last_o = state_reg.resp_last;
    assign burst_overflow_o = state_reg.burst_overflow;

endmodule
`default_nettype wire

// File: rwd_handler_checker.sv
// concurrent checks on the ports of the register write and capability handler
`timescale 1ns/1ns
`default_nettype none
module rwd_handler_checker
    import rwd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic frame_valid_i,
    input wire logic frame_cmd_i,
    input wire logic [7:0] frame_data_i,
    input wire logic frame_ready_o,
    input wire logic single_wr_en_i,
    input wire logic burst_wr_en_i,
    input wire logic read_en_i,
    input wire logic name_en_i,
    input wire logic status_en_i,
    input wire logic nationality_en_i,
    input wire logic wr_valid_o,
    input wire logic [6:0] wr_addr_o,
    input wire logic [7:0] wr_data_o,
    input wire logic wr_ready_i,
    input wire logic resp_valid_o,
    input wire logic [7:0] resp_data_o,
    input wire logic resp_last_o,
    input wire logic resp_ready_i,
    input wire logic burst_overflow_o
);
    // ************************************************************
    // helper state
    // ************************************************************
    logic take_cmd;
    logic cap_first_reg;
    // a command frame accepted in this cycle
    assign take_cmd = frame_valid_i & frame_ready_o & frame_cmd_i;
    // next response byte is a capability header; straps are read live
    always_ff @(posedge clk_i) begin
        if (rst_i | (resp_valid_o & resp_ready_i)) begin
            cap_first_reg <= 1'b0;
        end else if (take_cmd && frame_data_i == EXTENDED_CAPABILITY_COMMAND) begin
            cap_first_reg <= 1'b1;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence cap_take_s;
        take_cmd && frame_data_i == EXTENDED_CAPABILITY_COMMAND;
    endsequence
    sequence cap_head_s;
        cap_first_reg && resp_valid_o;
    endsequence
    cap_start_a: assert property (cap_take_s |-> !resp_valid_o ##2 resp_valid_o)
        else $error("capability answer not two cycles after request");
    cap_busy_a: assert property (cap_take_s |=> !frame_ready_o)
        else $error("frames still taken after capability request");
    hdr_reserved_a: assert property (cap_head_s |-> !resp_data_o[7] && !resp_data_o[3])
        else $error("reserved header bit set");
    hdr_flags_a: assert property (cap_head_s |-> resp_data_o[6:4] == {nationality_en_i, status_en_i, name_en_i} && resp_data_o[2:0] == {read_en_i, burst_wr_en_i, single_wr_en_i})
        else $error("header flags differ from straps");
    resp_hold_a: assert property (resp_valid_o && !resp_ready_i |=> resp_valid_o && $stable(resp_data_o) && $stable(resp_last_o))
        else $error("response byte changed while stalled");
    resp_end_a: assert property (resp_valid_o && resp_ready_i && resp_last_o |=> !resp_valid_o && frame_ready_o)
        else $error("response runs past its last byte");
    resp_busy_a: assert property (resp_valid_o |-> !frame_ready_o)
        else $error("frame taken during response");
    wr_hold_a: assert property (wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable({wr_addr_o, wr_data_o}))
        else $error("buffered write lost while stalled");
    ovf_clear_a: assert property (take_cmd |=> !burst_overflow_o)
        else $error("overflow flag kept over a new command");
endmodule
bind rwd_handler rwd_handler_checker i_chk (.clk_i(clk_i), .rst_i(rst_i),
    .frame_valid_i(frame_valid_i), .frame_cmd_i(frame_cmd_i), .frame_data_i(frame_data_i),
    .frame_ready_o(frame_ready_o), .single_wr_en_i(single_wr_en_i),
    .burst_wr_en_i(burst_wr_en_i), .read_en_i(read_en_i), .name_en_i(name_en_i),
    .status_en_i(status_en_i), .nationality_en_i(nationality_en_i),
    .wr_valid_o(wr_valid_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
    .wr_ready_i(wr_ready_i), .resp_valid_o(resp_valid_o), .resp_data_o(resp_data_o),
    .resp_last_o(resp_last_o), .resp_ready_i(resp_ready_i),
    .burst_overflow_o(burst_overflow_o));
`default_nettype wire

// File: rwd_pkg.sv
// constants and types for the register write and capability report handler
//
// Overview of operation
// - address byte with top bit clear then one data byte writes that register
// - several address and data pairs in one write command each reach their register
// - address byte with top bit set starts burst; up to 64 later data bytes go to that register
// - after a burst address no later frame is taken as an address
// - without write capability every data frame of a write command is dropped
// - name report returns a text of at most 15 ASCII characters
// - status report returns 1 to 15 bytes of device status
// - capability record holds at least its header and 1 to 15 bytes; here the header alone when no flag is set, six bytes at most
// - header bits 7 and 3 are driven to zero
// - bit 6 flags nationality code, sent after buffer length high byte
// - bit 5 set exactly when status report is implemented
// - bit 4 set exactly when name report is implemented
// - bit 2 flags register read; highest readable address follows header
// - bits 1 and 0 flag burst and single write; highest writable address follows
// - burst flagged adds 16-bit maximum burst count, low byte first
// - fields go header, read max, write max, length low, length high, nationality
// - advertised burst length is internal buffer size minus one
// - writable addresses run 0 to 127 with every lower address present
// - nationality byte is an 8-bit keyboard language code
package rwd_pkg;

    // ************************************************************
    // command codes on the link
    // ************************************************************
    localparam logic [7:0] REGISTER_WRITE_COMMAND = 8'h01;
    localparam logic [7:0] NAME_REPORT_COMMAND = 8'h02;
    localparam logic [7:0] STATUS_REPORT_COMMAND = 8'h03;
    localparam logic [7:0] EXTENDED_CAPABILITY_COMMAND = 8'h04;

    // ************************************************************
    // capability header bit positions
    // ************************************************************
    localparam int HDR_NATIONALITY_BIT = 6;
    localparam int HDR_STATUS_BIT = 5;
    localparam int HDR_NAME_BIT = 4;
    localparam int HDR_READ_BIT = 2;
    localparam int HDR_BURST_BIT = 1;
    localparam int HDR_SINGLE_BIT = 0;

    // ************************************************************
    // sizes and fixed content
    // ************************************************************
    localparam logic [6:0] MAX_WRITE_ADDR = 7'h7F;
    localparam logic [15:0] BURST_BUF_BYTES = 16'h0040;
    localparam logic [15:0] BURST_ADVERT = BURST_BUF_BYTES - 16'h0001;
    localparam logic [3:0] NAME_LEN = 4'hA;
    localparam logic [8*15-1:0] NAME_TEXT = {"CMD HANDLR", 40'h0000000000};
    localparam logic [3:0] STATUS_LEN = 4'h1;
    localparam logic [1:0] BUF_DEPTH = 2'h2;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WR_ADDR,
        ST_WR_DATA,
        ST_WR_BURST,
        ST_RESP
    } rwd_state_e;

    typedef enum logic [1:0] {
        RK_NAME,
        RK_STATUS,
        RK_CAP
    } rwd_resp_e;

endpackage

// File: rwd_sink.sv
// far side model: register sink and response reader, prompt or stalling
`timescale 1ns/1ns
`default_nettype none
module rwd_sink (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic slow_i,
    output logic wr_ready_o,
    output logic resp_ready_o
);
    logic [2:0] cnt_reg;
    // slow mode stalls writes seven cycles in eight and responses half the cycles, so the two-entry buffer fills up
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= 3'h0;
            wr_ready_o <= 1'b0;
            resp_ready_o <= 1'b0;
        end else begin
            cnt_reg <= cnt_reg + 3'h1;
            wr_ready_o <= !slow_i || cnt_reg == 3'h0;
            resp_ready_o <= !slow_i || cnt_reg[1];
        end
    end
endmodule
`default_nettype wire

// File: testbench.sv
// self-checking bench for the register write and capability handler
`timescale 1ns/1ns
`default_nettype none
module testbench
    import rwd_pkg::*;
;
    // ************************************************************
    // stimulus, model and monitors
    // ************************************************************
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic frame_valid_i = 1'b0;
    logic frame_cmd_i = 1'b0;
    logic cmd_done_i = 1'b0;
    logic slow = 1'b0;
    logic [7:0] frame_data_i = 8'h00;
    logic [7:0] nat_code = 8'h00;
    logic [7:0] stat_b = 8'h00;
    logic [5:0] straps = 6'h3F; // nat, status, name, read, burst, single
    logic [6:0] max_rd = 7'h00;
    logic frame_ready_o, wr_valid_o, wr_burst_o, wr_ready_i;
    logic resp_valid_o, resp_last_o, resp_ready_i, burst_overflow_o;
    logic [6:0] wr_addr_o;
    logic [7:0] wr_data_o, resp_data_o;
    logic [15:0] seen, qw[$], qr[$];
    logic [31:0] seed = 32'h6240ED8D;
    int num_errors = 0;
    int n_compared = 0;
    int k;
    always #20 clk_i = ~clk_i;
    rwd_handler i_dut (.clk_i(clk_i), .rst_i(rst_i), .frame_valid_i(frame_valid_i),
        .frame_cmd_i(frame_cmd_i), .frame_data_i(frame_data_i), .cmd_done_i(cmd_done_i),
        .frame_ready_o(frame_ready_o), .single_wr_en_i(straps[0]),
        .burst_wr_en_i(straps[1]), .read_en_i(straps[2]), .name_en_i(straps[3]),
        .status_en_i(straps[4]), .nationality_en_i(straps[5]), .max_read_addr_i(max_rd),
        .nationality_code_i(nat_code), .status_byte_i(stat_b), .wr_valid_o(wr_valid_o),
        .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .wr_burst_o(wr_burst_o),
        .wr_ready_i(wr_ready_i), .resp_valid_o(resp_valid_o), .resp_data_o(resp_data_o),
        .resp_last_o(resp_last_o), .resp_ready_i(resp_ready_i),
        .burst_overflow_o(burst_overflow_o));
    rwd_sink i_sink (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
        .wr_ready_o(wr_ready_i), .resp_ready_o(resp_ready_i));
    task end_of_test;
        if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task check(input logic [15:0] s, input logic [15:0] e);
        n_compared++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // next random word from the one passed in; the caller stores it back in seed
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // offer one frame, hold it until an edge sees ready high
    task send(input logic c, input logic [7:0] d);
        int i;
        @(negedge clk_i);
        frame_valid_i = 1'b1;
        frame_cmd_i = c;
        frame_data_i = d;
        for (i = 0; i < 2000 && frame_ready_o !== 1'b1; i++) @(negedge clk_i);
        if (i == 2000) begin
            num_errors++;
            end_of_test();
        end
        @(posedge clk_i);
    endtask
    task wp(input logic [7:0] a, input logic [7:0] d);
        qw.push_back({a[6:0], d, 1'b0});
        send(1'b0, a);
        send(1'b0, d);
    endtask
    task bd(input logic [6:0] a, input logic [7:0] d);
        qw.push_back({a, d, 1'b1});
        send(1'b0, d);
    endtask
    // release the frame line and end the write command
    task fin;
        @(negedge clk_i);
        frame_valid_i = 1'b0;
        cmd_done_i = 1'b1;
        @(negedge clk_i);
        cmd_done_i = 1'b0;
    endtask
    task drain;
        int i;
        fin();
        for (i = 0; i < 3000 && qw.size() + qr.size() > 0; i++) @(negedge clk_i);
        if (i == 3000) begin
            num_errors++;
            end_of_test();
        end
        repeat (6) @(negedge clk_i);
    endtask
    task pr(input logic [7:0] d);
        qr.push_back({8'h00, d});
    endtask
    // capability record built from the straps, unflagged fields left out
    task cap_exp;
        logic [15:0] adv;
        adv = 16'h0040 - 16'h0001;
        pr({1'b0, straps[5:3], 1'b0, straps[2:0]});
        if (straps[2]) pr({1'b0, max_rd});
        if (straps[1] | straps[0]) pr(8'h7F);
        if (straps[1]) pr(adv[7:0]);
        if (straps[1]) pr(adv[15:8]);
        if (straps[5]) pr(nat_code);
        qr[qr.size() - 1][8] = 1'b1;
    endtask
    // each accepted write is matched with the oldest note
    always @(negedge clk_i) begin
        if (!rst_i && wr_valid_o === 1'b1 && wr_ready_i === 1'b1) begin
            seen = {wr_addr_o, wr_data_o, wr_burst_o};
            check(seen, qw.size() > 0 ? qw.pop_front() : ~seen);
        end
        if (!rst_i && resp_valid_o === 1'b1 && resp_ready_i === 1'b1) begin
            seen = {7'h00, resp_last_o, resp_data_o};
            check(seen, qr.size() > 0 ? qr.pop_front() : ~seen);
        end
    end
    initial begin
        repeat (8) @(negedge clk_i);
        rst_i = 1'b0;
        send(1'b0, 8'h12); // data in idle is dropped
        for (k = 0; k < 5; k++) begin
            seed = lfsr(seed);
            @(negedge clk_i);
            straps = k == 4 ? 6'h3F : k == 0 ? 6'h00 : seed[5:0];
            max_rd = seed[14:8];
            nat_code = seed[23:16];
            stat_b = seed[31:24];
            slow = k[0];
            cap_exp();
            send(1'b1, EXTENDED_CAPABILITY_COMMAND);
            drain();
        end
        for (k = 0; k < NAME_LEN; k++) pr(NAME_TEXT[119 - 8 * k -: 8]);
        qr[qr.size() - 1][8] = 1'b1;
        send(1'b1, NAME_REPORT_COMMAND);
        qr.push_back({7'h00, 1'b1, stat_b});
        send(1'b1, STATUS_REPORT_COMMAND);
        drain();
        // pairs, top address, then burst whose data has the top bit set
        send(1'b1, REGISTER_WRITE_COMMAND);
        wp(8'h05, 8'hAA);
        wp(8'h7F, seed[7:0]);
        send(1'b0, 8'h83);
        bd(7'h03, 8'h85);
        bd(7'h03, 8'hFF);
        bd(7'h03, seed[15:8]);
        // a new command frame ends the burst
        send(1'b1, REGISTER_WRITE_COMMAND);
        send(1'b0, 8'h81);
        bd(7'h01, 8'h9C);
        send(1'b1, REGISTER_WRITE_COMMAND);
        wp(8'h02, 8'h3C);
        drain();
        // burst past the buffer with the sink stalling
        slow = 1'b1;
        send(1'b1, REGISTER_WRITE_COMMAND);
        send(1'b0, 8'h84);
        for (k = 0; k < 66; k++) begin
            seed = lfsr(seed);
            if (k < 64) bd(7'h04, seed[7:0]);
            else send(1'b0, seed[7:0]);
        end
        drain();
        check({15'h0000, burst_overflow_o}, 16'h0001);
        // no write forms, then single only with a burst address
        straps = 6'h3C;
        send(1'b1, REGISTER_WRITE_COMMAND);
        for (k = 0; k < 4; k++) send(1'b0, k[0] ? 8'h11 : 8'h83 - k[1]);
        @(negedge clk_i);
        straps = 6'h3D;
        send(1'b1, REGISTER_WRITE_COMMAND);
        send(1'b0, 8'h86);
        send(1'b0, 8'h05);
        send(1'b0, 8'h22);
        drain();
        straps = 6'h00;
        send(1'b1, NAME_REPORT_COMMAND);
        send(1'b1, STATUS_REPORT_COMMAND);
        drain();
        end_of_test();
    end
endmodule
`default_nettype wire
